/* design/timer_three_channel_compare.v */
// Three compare channels on a 16-bit PWM timer, with an APB register slave
//
// Functional notes
// - Each channel flags a match while the count equals its active compare value.
// - Software writes shadow values; shadow transfer pulse copies them into active registers.
// - State switching uses direction, run flag, zero match, channel match and mode field.
// - Software set and clear bits force each channel state bit to 1 or 0, except set while the hysteresis hold keeps the bit at 0.
// - Position inputs are ignored outside the hysteresis-like mode.
// - A match while counting up raises the rising compare event.
// - A match while counting down raises the falling compare event.
// - Compare events do not depend on the channel state bit.
// - Compare switching changes state bits only while the timer runs.
// - Match while counting up sets the state bit at the next timer event.
// - Zero match with coincident match while counting up sets the state bit.
// - Match while counting down clears the state bit at the next timer event.
// - Zero match without match while counting up clears the state bit.
// - Compare value zero keeps the state bit at 1, full duty.
// - Compare value above the period matches only at period plus one in center mode; state bit stays cleared.
// - Hysteresis-like mode clears the state bit when the position input becomes 0.
// - In that mode the bit stays 0 while the input is 0.
// - Position inputs are evaluated on the module clock.
// - Zero match flags count zero, one match flags count one.
// - Direction 0 up, 1 down; center mode turns down one event after period match.
// - Shadow transfer pulses only while enabled; enable has software set and clear bits.
//
// Decided for this implementation: the APB register port and the register offsets.
`timescale 1ns/1ps
`include "tcc_defines.vh"
module timer_three_channel_compare (
	input wire pclk, // Module clock, 40 MHz
	input wire presetn, // Asynchronous reset, active low
	input wire [7:0] paddr, // APB byte address
	input wire psel, // APB select
	input wire penable, // APB access phase
	input wire pwrite, // APB direction, high for write
	input wire [31:0] pwdata, // APB write data
	input wire [3:0] pstrb, // APB byte lane strobes
	output reg [31:0] prdata, // APB read data
	output wire pready, // APB ready, always high
	output wire pslverr, // APB error for unmapped address
	input wire [2:0] position_input, // Asynchronous position inputs per channel
	output wire [2:0] channel_state_bit, // Channel state bits
	output wire [2:0] channel_compare_match, // Count equals active compare value
	output reg [2:0] rising_compare_event, // Match pulse while counting up
	output reg [2:0] falling_compare_event, // Match pulse while counting down
	output wire zero_match, // Count is zero
	output wire one_match, // Count is one
	output wire period_match, // Count equals period
	output wire count_direction, // 0 up, 1 down
	output wire timer_run_flag, // Timer running
	output wire shadow_transfer_pulse, // Shadow to active transfer
	output wire [15:0] timer_count // Timer count value
);

	// =================================================================
	// State
	reg [4:0] ctrl_reg;
	reg [15:0] period_shadow_reg;
	reg [15:0] period_reg;
	reg [15:0] count_reg;
	reg [15:0] count_next;
	reg dir_reg;
	reg dir_next;
	reg [6:0] pre_reg;
	reg [15:0] shadow_cmp_reg [0:2];
	reg [15:0] active_cmp_reg [0:2];
	reg [11:0] mode_reg;
	reg [2:0] state_reg;
	reg [2:0] state_next;
	reg ste_reg;
	reg [2:0] rise_sticky_reg;
	reg [2:0] fall_sticky_reg;
	reg [2:0] pos_s1_reg;
	reg [2:0] pos_s2_reg;
	wire run;
	wire center;
	wire [2:0] prescale;
	wire tick;
	wire period_end;
	wire wr;
	wire rd_setup;
	wire [31:0] wmask;
	wire [31:0] wbits;
	wire [2:0] sw_set;
	wire [2:0] sw_clr;
	wire [2:0] rise_ev;
	wire [2:0] fall_ev;
	reg mapped;
	reg [31:0] rdata;
	// One loop variable per process, so that none has two drivers
	integer i;
	integer j;
	integer k;

	// =================================================================
	// Bus decode
	assign pready = 1'b1;
	assign wr = psel & penable & pwrite;
	assign rd_setup = psel & ~penable & ~pwrite;
	assign wmask = {{8{pstrb[3]}}, {8{pstrb[2]}}, {8{pstrb[1]}}, {8{pstrb[0]}}};
	assign wbits = pwdata & wmask;
	assign pslverr = psel & penable & ~mapped;

	// Address map check
	always @* begin
		case (paddr)
			`OFF_TIMER_CTRL, `OFF_PERIOD, `OFF_COUNT: mapped = 1'b1;
			`OFF_SHADOW_CMP0, `OFF_SHADOW_CMP1, `OFF_SHADOW_CMP2: mapped = 1'b1;
			`OFF_ACTIVE_CMP0, `OFF_ACTIVE_CMP1, `OFF_ACTIVE_CMP2: mapped = 1'b1;
			`OFF_MODE_SELECT, `OFF_STATE_MODIFY, `OFF_COMPARE_STATE: mapped = 1'b1;
			`OFF_SHADOW_CTRL, `OFF_EVENT_STATUS: mapped = 1'b1;
			default: mapped = 1'b0;
		endcase
	end

	// Read data mux; write-only registers read as zero
	always @* begin
		rdata = 32'h00000000;
		case (paddr)
			`OFF_TIMER_CTRL: rdata = {27'h0000000, ctrl_reg};
			`OFF_PERIOD: rdata = {16'h0000, period_reg};
			`OFF_COUNT: rdata = {16'h0000, count_reg};
			`OFF_SHADOW_CMP0: rdata = {16'h0000, shadow_cmp_reg[0]};
			`OFF_SHADOW_CMP1: rdata = {16'h0000, shadow_cmp_reg[1]};
			`OFF_SHADOW_CMP2: rdata = {16'h0000, shadow_cmp_reg[2]};
			`OFF_ACTIVE_CMP0: rdata = {16'h0000, active_cmp_reg[0]};
			`OFF_ACTIVE_CMP1: rdata = {16'h0000, active_cmp_reg[1]};
			`OFF_ACTIVE_CMP2: rdata = {16'h0000, active_cmp_reg[2]};
			`OFF_MODE_SELECT: rdata = {20'h00000, mode_reg};
			`OFF_COMPARE_STATE: rdata = {21'h000000, run, ste_reg, dir_reg, 5'h00, state_reg};
			`OFF_EVENT_STATUS: rdata = {25'h0000000, fall_sticky_reg, 1'b0, rise_sticky_reg};
			default: rdata = 32'h00000000;
		endcase
	end

	// Read data captured in the setup cycle, valid through the access phase
	always @(posedge pclk or negedge presetn) begin
		if (!presetn) begin
			prdata <= 32'h00000000;
		end else if (rd_setup) begin
			prdata <= rdata;
		end
	end

	// =================================================================
	// Timer control and configuration registers
	assign run = ctrl_reg[`CTRL_RUN_BIT];
	assign center = ctrl_reg[`CTRL_ALIGN_BIT];
	assign prescale = ctrl_reg[`CTRL_PRESCALE_MSB:`CTRL_PRESCALE_LSB];
	assign timer_run_flag = run;

	always @(posedge pclk or negedge presetn) begin
		if (!presetn) begin
			ctrl_reg <= `RST_CTRL;
			period_shadow_reg <= `RST_PERIOD;
			mode_reg <= `RST_MODE;
		end else if (wr) begin
			case (paddr)
				`OFF_TIMER_CTRL: ctrl_reg <= (ctrl_reg & ~wmask[4:0]) | wbits[4:0];
				`OFF_PERIOD: period_shadow_reg <= (period_shadow_reg & ~wmask[15:0]) | wbits[15:0];
				`OFF_MODE_SELECT: mode_reg <= (mode_reg & ~wmask[11:0]) | wbits[11:0];
				default: ;
			endcase
		end
	end

	// Shadow compare registers, software side only
	always @(posedge pclk or negedge presetn) begin
		if (!presetn) begin
			for (j = 0; j < 3; j = j + 1) begin
				shadow_cmp_reg[j] <= `RST_CMP;
			end
		end else if (wr) begin
			for (j = 0; j < 3; j = j + 1) begin
				if (paddr == `OFF_SHADOW_CMP0 + 8'h04 * j[7:0]) begin
					shadow_cmp_reg[j] <= (shadow_cmp_reg[j] & ~wmask[15:0]) | wbits[15:0];
				end
			end
		end
	end

	// =================================================================
	// Prescaler: one timer clock event per 2^prescale module clocks, cleared while stopped
	assign tick = run & (pre_reg == ((7'h01 << prescale) - 7'h01));

	always @(posedge pclk or negedge presetn) begin
		if (!presetn) begin
			pre_reg <= 7'h00;
		end else if (!run || tick) begin
			pre_reg <= 7'h00;
		end else begin
			pre_reg <= pre_reg + 7'h01;
		end
	end

	// =================================================================
	// Timer count and direction
	assign zero_match = (count_reg == 16'h0000);
	assign one_match = (count_reg == 16'h0001);
	assign period_match = (count_reg == period_reg);
	assign count_direction = dir_reg;
	assign timer_count = count_reg;
	// End of a timer period: wrap in edge mode, reaching zero downward in center mode
	assign period_end = center ? (dir_reg & one_match) : period_match;

	always @* begin
		count_next = count_reg;
		dir_next = dir_reg;
		if (tick) begin
			if (!center) begin
				dir_next = 1'b0;
				count_next = period_match ? 16'h0000 : count_reg + 16'h0001;
			end else if (!dir_reg) begin
				count_next = count_reg + 16'h0001;
				if (period_match) begin
					dir_next = 1'b1;
				end
			end else begin
				count_next = count_reg - 16'h0001;
				if (one_match) begin
					dir_next = 1'b0;
				end
			end
		end else if (!run && wr && paddr == `OFF_COUNT) begin
			count_next = (count_reg & ~wmask[15:0]) | wbits[15:0];
		end
	end

	always @(posedge pclk or negedge presetn) begin
		if (!presetn) begin
			count_reg <= 16'h0000;
			dir_reg <= 1'b0;
		end else begin
			count_reg <= count_next;
			dir_reg <= dir_next;
		end
	end

	// =================================================================
	// Shadow transfer: at period end while running, at once while stopped
	assign shadow_transfer_pulse = ste_reg & (~run | (tick & period_end));

	always @(posedge pclk or negedge presetn) begin
		if (!presetn) begin
			ste_reg <= 1'b0;
		end else if (wr && paddr == `OFF_SHADOW_CTRL && wbits[`SHCTRL_SET_BIT]) begin
			ste_reg <= 1'b1;
		end else if (wr && paddr == `OFF_SHADOW_CTRL && wbits[`SHCTRL_CLEAR_BIT]) begin
			ste_reg <= 1'b0;
		end else if (shadow_transfer_pulse) begin
			ste_reg <= 1'b0;
		end
	end

	// Active compare and period registers loaded from their shadows
	always @(posedge pclk or negedge presetn) begin
		if (!presetn) begin
			period_reg <= `RST_PERIOD;
			for (k = 0; k < 3; k = k + 1) begin
				active_cmp_reg[k] <= `RST_CMP;
			end
		end else if (shadow_transfer_pulse) begin
			period_reg <= period_shadow_reg;
			for (k = 0; k < 3; k = k + 1) begin
				active_cmp_reg[k] <= shadow_cmp_reg[k];
			end
		end
	end

	// =================================================================
	// Comparators and compare events
	genvar g;
	generate
		for (g = 0; g < 3; g = g + 1) begin : cmp
			assign channel_compare_match[g] = (count_reg == active_cmp_reg[g]);
			assign rise_ev[g] = tick & channel_compare_match[g] & ~dir_reg;
			assign fall_ev[g] = tick & channel_compare_match[g] & dir_reg;
		end
	endgenerate

	// Event pulses registered, one module clock each
	always @(posedge pclk or negedge presetn) begin
		if (!presetn) begin
			rising_compare_event <= 3'h0;
			falling_compare_event <= 3'h0;
		end else begin
			rising_compare_event <= rise_ev;
			falling_compare_event <= fall_ev;
		end
	end

	// Sticky event flags; write one to clear, a new event wins over the clear
	always @(posedge pclk or negedge presetn) begin
		if (!presetn) begin
			rise_sticky_reg <= 3'h0;
			fall_sticky_reg <= 3'h0;
		end else begin
			if (wr && paddr == `OFF_EVENT_STATUS) begin
				rise_sticky_reg <= (rise_sticky_reg & ~wbits[2:0]) | rise_ev;
				fall_sticky_reg <= (fall_sticky_reg & ~wbits[6:4]) | fall_ev;
			end else begin
				rise_sticky_reg <= rise_sticky_reg | rise_ev;
				fall_sticky_reg <= fall_sticky_reg | fall_ev;
			end
		end
	end

	// =================================================================
	// Position input synchronizer on the module clock
	always @(posedge pclk or negedge presetn) begin
		if (!presetn) begin
			pos_s1_reg <= 3'h0;
			pos_s2_reg <= 3'h0;
		end else begin
			pos_s1_reg <= position_input;
			pos_s2_reg <= pos_s1_reg;
		end
	end

	// =================================================================
	// Channel state bits
	assign sw_set = (wr && paddr == `OFF_STATE_MODIFY) ? wbits[2:0] : 3'h0;
	assign sw_clr = (wr && paddr == `OFF_STATE_MODIFY) ? wbits[10:8] : 3'h0;
	assign channel_state_bit = state_reg;

	// Switching rules, then software force, then hysteresis hold
	always @* begin
		state_next = state_reg;
		for (i = 0; i < 3; i = i + 1) begin
			if (tick) begin
				if (!dir_reg) begin
					if (channel_compare_match[i]) begin
						state_next[i] = 1'b1;
					end else if (zero_match) begin
						state_next[i] = 1'b0;
					end
				end else if (channel_compare_match[i]) begin
					state_next[i] = 1'b0;
				end
			end
			if (sw_set[i]) begin
				state_next[i] = 1'b1;
			end
			if (sw_clr[i]) begin
				state_next[i] = 1'b0;
			end
			// Position input only looked at in hysteresis-like mode
			if (mode_reg[4*i +: 4] == `MODE_HYSTERESIS && !pos_s2_reg[i]) begin
				state_next[i] = 1'b0;
			end
		end
	end

	always @(posedge pclk or negedge presetn) begin
		if (!presetn) begin
			state_reg <= 3'h0;
		end else begin
			state_reg <= state_next;
		end
	end

endmodule // timer_three_channel_compare

/* inc/tcc_defines.vh */
// Register offsets, field positions and reset values of the three-channel compare block
`ifndef TCC_DEFINES_VH
`define TCC_DEFINES_VH
// =====================================================================
// Register byte offsets
`define OFF_TIMER_CTRL 8'h00
`define OFF_PERIOD 8'h04
`define OFF_COUNT 8'h08
`define OFF_SHADOW_CMP0 8'h0c
`define OFF_SHADOW_CMP1 8'h10
`define OFF_SHADOW_CMP2 8'h14
`define OFF_ACTIVE_CMP0 8'h18
`define OFF_ACTIVE_CMP1 8'h1c
`define OFF_ACTIVE_CMP2 8'h20
`define OFF_MODE_SELECT 8'h24
`define OFF_STATE_MODIFY 8'h28
`define OFF_COMPARE_STATE 8'h2c
`define OFF_SHADOW_CTRL 8'h30
`define OFF_EVENT_STATUS 8'h34
// =====================================================================
// Field positions
`define CTRL_RUN_BIT 0
`define CTRL_ALIGN_BIT 1
`define CTRL_PRESCALE_LSB 2
`define CTRL_PRESCALE_MSB 4
`define MODIFY_SET_LSB 0
`define MODIFY_CLEAR_LSB 8
`define STATE_DIR_BIT 8
`define STATE_STE_BIT 9
`define STATE_RUN_BIT 10
`define SHCTRL_SET_BIT 0
`define SHCTRL_CLEAR_BIT 1
`define EVENT_RISE_LSB 0
`define EVENT_FALL_LSB 4
// =====================================================================
// Reset values and codes
`define RST_CTRL 5'h00
`define RST_PERIOD 16'hffff
`define RST_CMP 16'h0000
`define RST_MODE 12'h000
`define MODE_HYSTERESIS 4'h9
`endif

/* tb/pos_drv.sv */
// Position input source standing in for the outside comparator
`timescale 1ns/1ps
// ====================
// Position driver
module pos_drv (
	input wire pclk, // Clock
	input wire presetn, // Reset, active low
	input wire [2:0] level, // Wanted levels
	output reg [2:0] position_input // To the block
);
	// Levels move just after an edge; high means no fault
	always @(posedge pclk or negedge presetn) begin
		if (!presetn)
			position_input <= 3'h7;
		else
			position_input <= level;
	end
endmodule // pos_drv

/* tb/tb.sv */
// Register level test of the three-channel compare block
`timescale 1ns/1ps
`include "tcc_defines.vh"
// ====================
// Bench
module tb;
	reg pclk = 0;
	reg presetn = 0;
	reg [7:0] paddr = 8'h00;
	reg psel = 0;
	reg penable = 0;
	reg pwrite = 0;
	reg [31:0] pwdata = 32'h0;
	reg [3:0] pstrb = 4'hf;
	reg [2:0] level = 3'h7;
	wire [31:0] prdata;
	wire pready, pslverr, zm, om, pm, dir, run, stp;
	wire [2:0] pos, st, cm, re, fe;
	wire [15:0] cnt;
	integer miscompares = 0;
	integer n_tests = 0;
	integer cyc = 0;
	integer r0 = 0;
	integer r1 = 0;
	integer f0 = 0;
	// Snapshots of the event counters; the counters have one driver only
	integer b0 = 0;
	integer b1 = 0;
	integer bf = 0;
	reg [31:0] rd;
	reg err;
	initial forever #12.5 pclk = ~pclk;
	timer_three_channel_compare timer_three_channel_compare_inst (.pclk(pclk),
		.presetn(presetn), .paddr(paddr), .psel(psel), .penable(penable), .pwrite(pwrite),
		.pwdata(pwdata), .pstrb(pstrb), .prdata(prdata), .pready(pready), .pslverr(pslverr),
		.position_input(pos), .channel_state_bit(st), .channel_compare_match(cm),
		.rising_compare_event(re), .falling_compare_event(fe), .zero_match(zm),
		.one_match(om), .period_match(pm), .count_direction(dir), .timer_run_flag(run),
		.shadow_transfer_pulse(stp), .timer_count(cnt));
	pos_drv pos_drv_inst (.pclk(pclk), .presetn(presetn), .level(level), .position_input(pos));
	// Event counting and hang guard
	always @(posedge pclk) begin
		cyc <= cyc + 1;
		r0 <= r0 + (re[0] === 1'b1);
		r1 <= r1 + (re[1] === 1'b1);
		f0 <= f0 + (fe[0] === 1'b1);
		if (cyc == 5000) begin
			miscompares = miscompares + 1;
			report_and_stop;
		end
	end
	task chk(input string nm, input [31:0] e, input [31:0] g);
		n_tests = n_tests + 1;
		if (g !== e) begin
			miscompares = miscompares + 1;
			$display("unexpected %s: expected %h, seen %h", nm, e, g);
		end
	endtask
	// One bus transfer, held until ready is seen
	task apb(input [7:0] a, input w, input [31:0] d);
		@(posedge pclk);
		psel <= 1;
		penable <= 0;
		paddr <= a;
		pwrite <= w;
		pwdata <= d;
		@(posedge pclk);
		penable <= 1;
		@(posedge pclk);
		while (pready !== 1'b1) @(posedge pclk);
		rd = prdata;
		err = pslverr;
		psel <= 0;
		penable <= 0;
		#1;
	endtask
	task wr(input [7:0] a, input [31:0] d);
		apb(a, 1'b1, d);
	endtask
	task rdc(input string nm, input [7:0] a, input [31:0] e);
		apb(a, 1'b0, 32'h0);
		chk(nm, e, rd);
	endtask
	task idle(input integer n);
		repeat (n) @(posedge pclk);
		#1;
	endtask
	// Bounded wait for a count value in a direction
	task wait_cnt(input [15:0] v, input d);
		integer k;
		k = 0;
		while ((cnt !== v || dir !== d) && k < 100) begin
			idle(1);
			k = k + 1;
		end
		chk("count wait", 0, k == 100);
	endtask
	task report_and_stop;
		$display("comparisons %0d, mismatches %0d", n_tests, miscompares);
		if (miscompares == 0 && n_tests > 0)
			$display("RESULT: PASS");
		else
			$display("RESULT: FAIL");
		$finish;
	endtask
	initial begin
		repeat (8) @(posedge pclk);
		presetn <= 1;
		rdc("period", `OFF_PERIOD, 32'hffff);
		rdc("mode", `OFF_MODE_SELECT, 0);
		chk("zero flag", 1, zm);
		chk("one flag", 0, om);
		chk("match", 3'h7, cm);
		apb(8'h38, 1'b0, 32'h0);
		chk("slverr", 1, err);
		$display("test reset done");
		wr(`OFF_PERIOD, 9);
		wr(`OFF_SHADOW_CMP0, 3);
		wr(`OFF_SHADOW_CMP2, 10);
		rdc("active0", `OFF_ACTIVE_CMP0, 0);
		wr(`OFF_SHADOW_CTRL, 1);
		rdc("active0", `OFF_ACTIVE_CMP0, 3);
		rdc("active2", `OFF_ACTIVE_CMP2, 10);
		rdc("period", `OFF_PERIOD, 9);
		rdc("status", `OFF_COMPARE_STATE, 0);
		$display("test shadow done");
		wr(`OFF_STATE_MODIFY, 32'h7);
		idle(5);
		chk("state", 3'h7, st);
		wr(`OFF_STATE_MODIFY, 32'h700);
		chk("state", 3'h0, st);
		$display("test force done");
		wr(`OFF_TIMER_CTRL, 1);
		chk("run", 1, run);
		wait_cnt(5, 0);
		chk("state", 3'h3, st);
		b0 = r0;
		b1 = r1;
		wait_cnt(1, 0);
		chk("state", 3'h2, st);
		wait_cnt(5, 0);
		chk("state", 3'h3, st);
		chk("rise0", 1, r0 - b0);
		chk("rise1", 1, r1 - b1);
		rdc("events", `OFF_EVENT_STATUS, 3);
		// Stop first: a new event would win over the clear
		wr(`OFF_TIMER_CTRL, 0);
		wr(`OFF_EVENT_STATUS, 32'h77);
		rdc("events", `OFF_EVENT_STATUS, 0);
		$display("test edge done");
		wr(`OFF_COUNT, 0);
		wr(`OFF_TIMER_CTRL, 3);
		wait_cnt(8, 1);
		bf = f0;
		b0 = r0;
		wait_cnt(1, 1);
		chk("fall0", 1, f0 - bf);
		chk("rise0", 0, r0 - b0);
		chk("state0", 0, st[0]);
		wr(`OFF_TIMER_CTRL, 0);
		$display("test center done");
		wr(`OFF_MODE_SELECT, 32'h900);
		wr(`OFF_STATE_MODIFY, 7);
		@(posedge pclk);
		level <= 3'h2;
		idle(3);
		chk("state", 3'h7, st);
		idle(1);
		chk("state", 3'h3, st);
		wr(`OFF_STATE_MODIFY, 7);
		chk("state", 3'h3, st);
		@(posedge pclk);
		level <= 3'h7;
		idle(5);
		wr(`OFF_STATE_MODIFY, 7);
		chk("state", 3'h7, st);
		$display("test position done");
		report_and_stop;
	end
endmodule // tb

/* tb/tcc_props.sv */
// Port level checks of the three-channel compare block
`timescale 1ns/1ps
// ====================
// Checker
module tcc_props (
	input wire pclk, // Clock
	input wire presetn, // Reset, active low
	input wire psel, // Select
	input wire penable, // Access phase
	input wire pwrite, // Direction
	input wire [2:0] channel_state_bit, // State bits
	input wire [2:0] channel_compare_match, // Matches
	input wire [2:0] rising_compare_event, // Up events
	input wire [2:0] falling_compare_event, // Down events
	input wire zero_match, // Count zero
	input wire one_match, // Count one
	input wire period_match, // Count at period
	input wire count_direction, // Direction
	input wire timer_run_flag, // Running
	input wire shadow_transfer_pulse, // Transfer
	input wire [15:0] timer_count // Count
);
	default clocking @(posedge pclk); endclocking
	default disable iff (!presetn);
	// Completed register write
	wire wr = psel & penable & pwrite;
	a_zero_flag: assert property (
		zero_match == (timer_count == 16'h0000)) else $error("zero flag wrong");
	a_one_flag: assert property (
		one_match == (timer_count == 16'h0001)) else $error("one flag wrong");
	a_rise_cause: assert property (rising_compare_event != 3'h0 |->
		!$past(count_direction) && (rising_compare_event & ~$past(channel_compare_match)) == 3'h0)
		else $error("rising event without up match");
	a_fall_cause: assert property (falling_compare_event != 3'h0 |->
		$past(count_direction) && (falling_compare_event & ~$past(channel_compare_match)) == 3'h0)
		else $error("falling event without down match");
	a_stop_hold: assert property ($rose(channel_state_bit[0]) |->
		$past(timer_run_flag) || $past(wr)) else $error("state set while stopped");
	a_up_sets: assert property (rising_compare_event[0] && !$past(wr) |->
		channel_state_bit[0]) else $error("state not set on up match");
	a_down_clears: assert property (falling_compare_event[0] && !$past(wr) |->
		!channel_state_bit[0]) else $error("state not cleared on down match");
	a_pulse_once: assert property (
		shadow_transfer_pulse |=> !shadow_transfer_pulse) else $error("transfer pulse too long");
	a_dir_down: assert property (
		$rose(count_direction) |-> $past(period_match)) else $error("turned down early");
	a_dir_up: assert property (
		$fell(count_direction) |-> $past(one_match)) else $error("turned up early");
	c_rise: cover property (rising_compare_event[0]);
	c_fall: cover property (falling_compare_event[0]);
	c_pulse: cover property (shadow_transfer_pulse);
endmodule // tcc_props
bind timer_three_channel_compare tcc_props tcc_props_inst (.pclk, .presetn, .psel, .penable,
	.pwrite, .channel_state_bit, .channel_compare_match, .rising_compare_event,
	.falling_compare_event, .zero_match, .one_match, .period_match, .count_direction,
	.timer_run_flag, .shadow_transfer_pulse, .timer_count);
